// [logic/utx_top.sv]
// uart transmitter with baud generator, enable logic and register port
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - bit time is 64*(N+1) or 16*(N+1) clocks, picked by speed bit
// - free running 8-bit divisor timer, period set by divisor 0..255
// - frame: start, 8 or 9 data, one or two two_stop_select, optional parity
// - reset format is eight data, no parity, one stop
// - transmit and receive share one format and one bit rate
// - data leave the shift register lsb first
// - all enables set: pins are tx out and rx in, tx idles high
// - global disable floats pins and empties the data buffer
// - disable clears enables, break, rx flags; sets idle and empty flags
// - global disable two_stop_select activity at once; re-enable keeps config
// - stop count selection affects transmitter only
// - parity or address marker takes the top data position
// - ninth bit in nine-bit mode comes from the tx ninth bit control
// - shift register reloads only after previous stop bits
// - sending starts with tx enable set, data written, shift clock
// - clearing tx enable aborts, resets transmitter, floats tx pin
// - data writes ignored while the empty flag is low
// - empty flag set when buffer free; interrupt when enabled
// - busy write is held; idle write goes straight to shifter
// - idle flag set at frame end; cleared like the empty flag
// - one data address: writes send, reads return received data
// - parity type 0 even, 1 odd
// - break holds tx low at least 13 bit times, until cleared
module utx_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_avail_i,
  input wire logic rx_idle_i,
  input wire logic [3:0] rx_err_i,
  output logic rx_read_o,
  output logic rx_flush_o,
  output logic rx_pin_en_o,
  output logic tx_o,
  output logic tx_oe_o,
  output logic irq_o
);
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] div;
  logic [7:0] hold;
  logic hold_full;
  logic hold_ninth;
  logic tx_idle;
  logic st_touched;
  logic [3:0] rx_err_q;
  logic [5:0] pre_cnt;
  logic [7:0] div_cnt;
  logic [9:0] shreg;
  logic [3:0] bit_cnt;
  logic [3:0] brk_cnt;
  utx_pkg::utx_state_t state;
  logic [7:0] next_rdata;
  logic [9:0] next_shreg;

  wire uart_en = ctrl_a[utx_pkg::CA_UART_EN];
  wire tx_en = ctrl_b[utx_pkg::CB_TX_EN];
  wire tx_run = uart_en && tx_en;
  wire brk = ctrl_a[utx_pkg::CA_BREAK];
  wire ninth = ctrl_a[utx_pkg::CA_NINTH];
  wire par_en = ctrl_a[utx_pkg::CA_PAR_EN];
  wire tx_empty = !hold_full;
  wire rx_avail_s = rx_avail_i && uart_en;

  // register decode
  wire wr_data = wr_i && addr_i == utx_pkg::ADDR_DATA;
  wire wr_div = wr_i && addr_i == utx_pkg::ADDR_DIV;
  wire wr_ca = wr_i && addr_i == utx_pkg::ADDR_CTRL_A;
  wire wr_cb = wr_i && addr_i == utx_pkg::ADDR_CTRL_B;
  wire rd_st = rd_i && addr_i == utx_pkg::ADDR_STATUS;
  wire rd_data = rd_i && addr_i == utx_pkg::ADDR_DATA;
  // buffer accepts only when empty and after status access
  wire data_take = wr_data && tx_empty && uart_en;
  wire seq_clear = wr_data && st_touched;
  wire disable_now = wr_ca && !wdata_i[utx_pkg::CA_UART_EN];

  // baud prescaler and free running 8-bit divisor timer
  wire [5:0] pre_max = ctrl_b[utx_pkg::CB_SPEED] ?
    utx_pkg::PRE_HIGH : utx_pkg::PRE_LOW;
  wire pre_wrap = pre_cnt >= pre_max;
  wire div_wrap = div_cnt >= div;
  wire baud_tick = pre_wrap && div_wrap;

  // frame length: data bits plus optional parity fold into top slot
  wire [3:0] data_len = ninth ? 4'h9 : 4'h8;
  wire [3:0] stop_len = ctrl_a[utx_pkg::CA_TWO_STOP] ? 4'h2 : 4'h1;
  wire [3:0] frame_len = 4'h1 + data_len + stop_len;

  // build the frame word from held data
  wire [7:0] par_src = ninth ? hold : {1'b0, hold[6:0]};
  wire par_bit = ^par_src ^ ctrl_a[utx_pkg::CA_PAR_TYPE];
  wire top_bit = par_en ? par_bit :
    (ninth ? hold_ninth : hold[7]);
  wire [8:0] frame_word = ninth ? {top_bit, hold} :
    {1'b1, top_bit, hold[6:0]};

  wire shift_end = state == utx_pkg::UTX_SEND && baud_tick &&
    bit_cnt == frame_len - 4'h1;
  wire brk_end = state == utx_pkg::UTX_BRK && baud_tick &&
    brk_cnt >= utx_pkg::BREAK_BITS && !brk;
  wire can_load = tx_run && hold_full && !brk &&
    (state == utx_pkg::UTX_IDLE || shift_end);
  wire go_break = tx_run && brk && !hold_full &&
    (state == utx_pkg::UTX_IDLE || shift_end);
  // frame start from idle restarts the timer so the start bit is whole
  wire realign = state == utx_pkg::UTX_IDLE && (can_load || go_break);

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      utx_pkg::ADDR_DATA: next_rdata = rx_data_i;
      utx_pkg::ADDR_DIV: next_rdata = div;
      utx_pkg::ADDR_CTRL_A: next_rdata = ctrl_a;
      utx_pkg::ADDR_CTRL_B: next_rdata = ctrl_b;
      utx_pkg::ADDR_STATUS: next_rdata = {rx_err_q, rx_idle_i || !uart_en,
        rx_avail_s, tx_idle, tx_empty};
      default: next_rdata = 8'h00;
    endcase
  end

  // shift register next value: lsb first out of bit 0
  always_comb begin
    next_shreg = shreg;
    if (can_load) begin
      next_shreg = {frame_word, 1'b0};
    end else if (state == utx_pkg::UTX_SEND && baud_tick) begin
      next_shreg = {1'b1, shreg[9:1]};
    end
  end

  // control registers; disable clears listed bits, keeps the rest
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_a <= utx_pkg::CTRL_A_RST;
      ctrl_b <= utx_pkg::CTRL_B_RST;
      div <= utx_pkg::DIV_RST;
    end else begin
      if (wr_div) begin
        div <= wdata_i;
      end
      if (disable_now) begin
        ctrl_a <= {wdata_i[7:3], 1'b0, wdata_i[1:0]};
        ctrl_b <= {2'b00, ctrl_b[5:0]};
      end else if (wr_ca) begin
        ctrl_a <= wdata_i;
      end else if (wr_cb) begin
        ctrl_b <= wdata_i;
      end
    end
  end

  // status access latch for the clear sequence
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_touched <= 1'b0;
    end else if (rd_st) begin
      st_touched <= 1'b1;
    end else if (wr_data || rd_data) begin
      st_touched <= 1'b0;
    end
  end

  // held rx error flags, cleared on disable
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_err_q <= 4'h0;
    end else if (!uart_en) begin
      rx_err_q <= 4'h0;
    end else begin
      rx_err_q <= rx_err_i;
    end
  end

  // data buffer: write fills it, load into shifter frees it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold <= 8'h00;
      hold_full <= 1'b0;
      hold_ninth <= 1'b0;
    end else if (!uart_en || disable_now) begin
      hold_full <= 1'b0;
    end else if (data_take && seq_clear) begin
      hold <= wdata_i;
      hold_ninth <= ctrl_a[utx_pkg::CA_TX_NINTH];
      hold_full <= 1'b1;
    end else if (can_load) begin
      hold_full <= 1'b0;
    end
  end

  // idle flag: set wins over the software clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_idle <= 1'b1;
    end else if (!uart_en || shift_end || brk_end) begin
      tx_idle <= 1'b1;
    end else if (seq_clear) begin
      tx_idle <= 1'b0;
    end
  end

  // prescaler and divisor timer, runs freely within a frame
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt <= 6'h00;
      div_cnt <= 8'h00;
    end else if (realign) begin
      pre_cnt <= 6'h00;
      div_cnt <= 8'h00;
    end else if (pre_wrap) begin
      pre_cnt <= 6'h00;
      div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  // transmit sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= utx_pkg::UTX_IDLE;
      shreg <= 10'h3FF;
      bit_cnt <= 4'h0;
      brk_cnt <= 4'h0;
    end else if (!tx_run) begin
      state <= utx_pkg::UTX_IDLE;
      shreg <= 10'h3FF;
      bit_cnt <= 4'h0;
      brk_cnt <= 4'h0;
    end else begin
      shreg <= next_shreg;
      if (can_load) begin
        state <= utx_pkg::UTX_SEND;
        bit_cnt <= 4'h0;
      end else if (go_break) begin
        state <= utx_pkg::UTX_BRK;
        brk_cnt <= 4'h0;
      end else begin
        case (state)
          utx_pkg::UTX_IDLE: bit_cnt <= 4'h0;
          utx_pkg::UTX_SEND: begin
            if (shift_end) begin
              state <= utx_pkg::UTX_IDLE;
            end else if (baud_tick) begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          utx_pkg::UTX_BRK: begin
            if (brk_end) begin
              state <= utx_pkg::UTX_SEND; // stop bits after break
              shreg <= 10'h3FF;
              bit_cnt <= frame_len - stop_len;
            end else if (baud_tick && brk_cnt < utx_pkg::BREAK_BITS) begin
              brk_cnt <= brk_cnt + 4'h1;
            end
          end
          default: state <= utx_pkg::UTX_IDLE;
        endcase
      end
    end
  end

  // registered outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      tx_o <= 1'b1;
      tx_oe_o <= 1'b0;
      irq_o <= 1'b0;
      rx_read_o <= 1'b0;
      rx_flush_o <= 1'b1;
      rx_pin_en_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
      tx_o <= state == utx_pkg::UTX_BRK ? 1'b0 :
        next_shreg[0] | (state == utx_pkg::UTX_IDLE && !can_load);
      tx_oe_o <= tx_run;
      irq_o <= tx_empty && uart_en && ctrl_b[utx_pkg::CB_TE_IE];
      rx_read_o <= rd_data && uart_en;
      rx_flush_o <= !uart_en;
      rx_pin_en_o <= uart_en && ctrl_b[utx_pkg::CB_RX_EN];
    end
  end
endmodule // utx_top
`default_nettype wire

// [logic/utx_pkg.sv]
// package of register offsets, fields and constants for the uart transmitter
package utx_pkg;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_DIV = 3'h1;
  localparam logic [2:0] ADDR_CTRL_A = 3'h2;
  localparam logic [2:0] ADDR_CTRL_B = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_RXDATA = 3'h5;
  // ctrl_a fields
  localparam int CA_UART_EN = 7;
  localparam int CA_NINTH = 6;
  localparam int CA_PAR_EN = 5;
  localparam int CA_PAR_TYPE = 4;
  localparam int CA_TWO_STOP = 3;
  localparam int CA_BREAK = 2;
  localparam int CA_TX_NINTH = 0;
  // ctrl_b fields
  localparam int CB_TX_EN = 7;
  localparam int CB_RX_EN = 6;
  localparam int CB_SPEED = 5;
  localparam int CB_TE_IE = 0;
  // status fields
  localparam int ST_PARITY = 7;
  localparam int ST_NOISE = 6;
  localparam int ST_FRAMING = 5;
  localparam int ST_OVERRUN = 4;
  localparam int ST_RX_IDLE = 3;
  localparam int ST_RX_AVAIL = 2;
  localparam int ST_TX_IDLE = 1;
  localparam int ST_TX_EMPTY = 0;
  // reset values: 8-N-1, all disabled
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  // prescale per bit: 64 low speed, 16 high speed
  localparam logic [5:0] PRE_LOW = 6'h3F;
  localparam logic [5:0] PRE_HIGH = 6'h0F;
  localparam logic [3:0] BREAK_BITS = 4'hD;
  typedef enum logic [1:0] {
    UTX_IDLE = 2'b00,
    UTX_SEND = 2'b01,
    UTX_BRK = 2'b10
  } utx_state_t;
endpackage

// [testbench/utx_props.sv]
// port checker for the uart transmitter
`timescale 1ns/1ns
`default_nettype none
module utx_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_read_o,
  input wire logic rx_flush_o,
  input wire logic rx_pin_en_o,
  input wire logic tx_oe_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // register writes that drop an enable, and data reads
  sequence uart_off;
    wr_i && addr_i == utx_pkg::ADDR_CTRL_A && !wdata_i[7];
  endsequence
  sequence tx_off;
    wr_i && addr_i == utx_pkg::ADDR_CTRL_B && !wdata_i[7];
  endsequence
  sequence data_rd;
    rd_i && addr_i == utx_pkg::ADDR_DATA;
  endsequence
  // read port and pin control relations
  rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  rd_data_a: assert property (data_rd ##0 rx_pin_en_o |=>
    rdata_o == $past(rx_data_i)) else $error("data read wrong");
  rx_pop_a: assert property (rx_read_o |->
    $past(rd_i && addr_i == utx_pkg::ADDR_DATA)) else $error("stray pop");
  pins_off_a: assert property (rx_flush_o |->
    !rx_pin_en_o && !tx_oe_o) else $error("pins driven while off");
  irq_off_a: assert property (rx_flush_o |-> !irq_o)
    else $error("irq while off");
  off_float_a: assert property (uart_off |-> ##[1:2]
    (rx_flush_o && !tx_oe_o)) else $error("disable not taken");
  tx_stop_a: assert property (tx_off |-> ##[1:2] !tx_oe_o)
    else $error("tx pin still driven");
  oe_cause_a: assert property ($changed(tx_oe_o) |->
    $past(wr_i) || $past(wr_i, 2)) else $error("pin enable moved alone");
endmodule // utx_props
`default_nettype wire

// [testbench/utx_peer.sv]
// remote serial receiver watching the transmit line
`timescale 1ns/1ns
`default_nettype none
module utx_peer (
  input wire logic mclk_i,
  input wire logic tx_i,
  input wire logic oe_i,
  input wire logic [15:0] bits_i,
  input wire logic [3:0] nb_i,
  output logic [8:0] word_o,
  output logic stop_o,
  output logic [15:0] frames_o
);
  logic ok;
  // one frame per start edge, counted only if driven at the start and at every sample point
  initial begin
    frames_o = 16'h0000;
    word_o = 9'h000;
    stop_o = 1'b0;
    forever begin
      @(negedge mclk_i);
      if (oe_i && !tx_i) begin
        ok = 1'b1;
        word_o = 9'h000;
        // move to mid bit before sampling
        repeat (bits_i >> 1) @(negedge mclk_i);
        for (int k = 0; k <= nb_i; k++) begin
          repeat (bits_i) @(negedge mclk_i);
          ok = ok && oe_i;
          if (k == nb_i) stop_o = tx_i;
          else word_o[k] = tx_i;
        end
        if (ok) frames_o = frames_o + 16'h0001;
      end
    end
  end
endmodule // utx_peer
`default_nettype wire

// [testbench/uart_tx_baud_control_tb.sv]
// self-checking bench for the uart transmitter
`timescale 1ns/1ns
`default_nettype none
module uart_tx_baud_control_tb;
  typedef struct {
    logic [7:0] ca;
    logic [7:0] cb;
    logic [7:0] d;
    logic [3:0] nb;
    logic [8:0] ex;
  } utx_row_t;
  // config, data and the word expected on the line
  utx_row_t rows [6] = '{
    '{8'h80, 8'hA1, 8'hA5, 4'h8, 9'h0A5},
    '{8'hB0, 8'hA1, 8'h35, 4'h8, 9'h0B5},
    '{8'hA0, 8'hA1, 8'h35, 4'h8, 9'h035},
    '{8'hC1, 8'hA1, 8'h3C, 4'h9, 9'h13C},
    '{8'hE0, 8'hA1, 8'h07, 4'h9, 9'h107},
    '{8'h88, 8'h81, 8'hA5, 4'h8, 9'h0A5}};
  logic mclk_i, rst_n_i, wr_i, rd_i, rx_avail_i, rx_idle_i, stop;
  logic rx_read_o, rx_flush_o, rx_pin_en_o, tx_o, tx_oe_o, irq_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, rx_data_i;
  logic [8:0] word;
  logic [3:0] rx_err_i, nb;
  logic [15:0] bits, frames, f;
  int bad_count, n_compared, cyc, n;
  utx_top u_utx_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_data_i(rx_data_i), .rx_avail_i(rx_avail_i), .rx_idle_i(rx_idle_i),
    .rx_err_i(rx_err_i), .rx_read_o(rx_read_o), .rx_flush_o(rx_flush_o),
    .rx_pin_en_o(rx_pin_en_o), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
    .irq_o(irq_o));
  utx_peer u_utx_peer (.mclk_i(mclk_i), .tx_i(tx_o), .oe_i(tx_oe_o),
    .bits_i(bits), .nb_i(nb), .word_o(word), .stop_o(stop),
    .frames_o(frames));
  // clock and hang guard
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  // compare, bus cycles and waits
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, e);
    @(posedge mclk_i);
  endtask
  task automatic idle(input int c);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (c) @(posedge mclk_i);
  endtask
  task automatic send(input logic [7:0] d);
    rd(utx_pkg::ADDR_STATUS, 8'h00, 8'h00);
    wr(utx_pkg::ADDR_DATA, d);
    idle(2);
  endtask
  task automatic wait_fr(input logic [15:0] want);
    n = 0;
    while (frames < want && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    chk(frames, want);
  endtask
  task automatic wait_tx(input logic v, input int lim);
    n = 0;
    while (tx_o !== v && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    chk(tx_o, v);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    cyc = 0;
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    rx_data_i = 8'h5A;
    rx_avail_i = 1'b1;
    rx_idle_i = 1'b1;
    rx_err_i = 4'hF;
    bits = 16'h0020;
    nb = 4'h8;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1 chk({tx_oe_o, rx_flush_o, irq_o}, 3'b010);
    @(posedge mclk_i);
    rd(utx_pkg::ADDR_CTRL_A, 8'hFF, 8'h00);
    rd(utx_pkg::ADDR_STATUS, 8'hFF, 8'h0B);
    wr(utx_pkg::ADDR_DIV, 8'h01);
    foreach (rows[i]) begin
      wr(utx_pkg::ADDR_CTRL_A, rows[i].ca);
      wr(utx_pkg::ADDR_CTRL_B, rows[i].cb);
      bits = rows[i].cb[5] ? 16'h0020 : 16'h0080;
      nb = rows[i].nb;
      f = frames;
      send(rows[i].d);
      wait_fr(f + 16'h0001);
      chk(word, rows[i].ex);
      chk({stop, irq_o}, 2'b11);
      idle(3 * bits);
    end
    // back to back: second held, third and unsequenced writes dropped
    wr(utx_pkg::ADDR_CTRL_B, 8'hA1);
    bits = 16'h0020;
    f = frames;
    send(8'h11);
    rd(utx_pkg::ADDR_STATUS, 8'h03, 8'h01);
    wr(utx_pkg::ADDR_DATA, 8'h22);
    idle(2);
    rd(utx_pkg::ADDR_STATUS, 8'h01, 8'h00);
    wr(utx_pkg::ADDR_DATA, 8'h33);
    idle(2);
    chk(irq_o, 1'b0);
    wait_fr(f + 16'h0001);
    chk(word, 9'h011);
    wait_fr(f + 16'h0002);
    chk(word, 9'h022);
    wr(utx_pkg::ADDR_DATA, 8'h44);
    idle(20 * bits);
    chk(frames, f + 16'h0002);
    // data before transmit enable, then abort by transmit enable
    wr(utx_pkg::ADDR_CTRL_B, 8'h21);
    f = frames;
    send(8'h55);
    idle(4 * bits);
    chk(frames, f);
    wr(utx_pkg::ADDR_CTRL_B, 8'hA1);
    wait_fr(f + 16'h0001);
    chk(word, 9'h055);
    idle(3 * bits);
    send(8'h66);
    idle(3 * bits);
    wr(utx_pkg::ADDR_CTRL_B, 8'h21);
    idle(15 * bits);
    chk(frames, f + 16'h0001);
    // global disable in mid frame, then re-enable
    wr(utx_pkg::ADDR_CTRL_B, 8'hA1);
    send(8'h77);
    idle(3 * bits);
    wr(utx_pkg::ADDR_CTRL_A, 8'h00);
    idle(2);
    rd(utx_pkg::ADDR_STATUS, 8'hFF, 8'h0B);
    rd(utx_pkg::ADDR_CTRL_B, 8'hFF, 8'h21);
    rd(utx_pkg::ADDR_DIV, 8'hFF, 8'h01);
    wr(utx_pkg::ADDR_CTRL_A, 8'h88);
    idle(15 * bits);
    chk(frames, f + 16'h0001);
    wr(utx_pkg::ADDR_CTRL_B, 8'hE1);
    idle(2);
    rd(utx_pkg::ADDR_DATA, 8'hFF, 8'h5A);
    rd(3'h7, 8'hFF, 8'h00);
    // break holds the line low, released after clearing
    wr(utx_pkg::ADDR_CTRL_A, 8'h84);
    wait_tx(1'b0, 4 * bits);
    idle(13 * bits);
    chk(tx_o, 1'b0);
    wr(utx_pkg::ADDR_CTRL_A, 8'h80);
    wait_tx(1'b1, 16 * bits);
    give_verdict();
  end
endmodule // uart_tx_baud_control_tb
bind utx_top utx_props u_utx_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .rx_data_i(rx_data_i), .rx_read_o(rx_read_o),
  .rx_flush_o(rx_flush_o), .rx_pin_en_o(rx_pin_en_o), .tx_oe_o(tx_oe_o),
  .irq_o(irq_o));
`default_nettype wire
